// ---- core/ssp_map.svh ----
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// Data path and buffer shape
`define SSP_DATA_W 16
`define SSP_FIFO_DEPTH 8
`define SSP_FIFO_HALF 4

// Frame length field holds length minus one
`define SSP_WIDTH_M1_MIN 4'h3
`define SSP_WIDTH_M1_MAX 4'hf

// Rate generator field widths
`define SSP_PRE_W 8
`define SSP_DIV_W 8

// Interrupt source positions
`define SSP_INT_W 3
`define SSP_INT_TX_LOW 0
`define SSP_INT_RX_HIGH 1
`define SSP_INT_RX_OVR 2

`endif

// ---- core/ssp_pkg.sv ----
package ssp_pkg;

   typedef enum logic [1:0] {
      SSP_FMT_SPI = 2'h0,
      SSP_FMT_PULSE = 2'h1,
      SSP_FMT_CMD = 2'h2
   } ssp_fmt_t;

   // Gray sequence idle, start, transfer, done
   typedef enum logic [1:0] {
      SSP_ST_IDLE = 2'h0,
      SSP_ST_START = 2'h1,
      SSP_ST_XFER = 2'h3,
      SSP_ST_DONE = 2'h2
   } ssp_state_t;

endpackage : ssp_pkg

// ---- core/ssp_fifo.sv ----
`timescale 1ns/1ps
module ssp_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8,
   parameter int CW = $clog2(DEPTH) + 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Fill side
   input wire logic wr_i,
   input wire logic [W-1:0] wr_data_i,
   // Drain side
   input wire logic rd_i,
   output logic [W-1:0] rd_data_o,
   // Status
   output logic [CW-1:0] count_o,
   output logic full_o,
   output logic empty_o
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] count_r;

   // Requests on a full or empty buffer are dropped, never corrupt it
   wire do_wr = wr_i & ~full_o;
   wire do_rd = rd_i & ~empty_o;

   assign full_o = (count_r == CW'(DEPTH));
   assign empty_o = (count_r == '0);
   assign count_o = count_r;
   assign rd_data_o = mem[rd_ptr_r];

   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem[wr_ptr_r] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
         end
         if (do_rd) begin
            rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
         end
         if (do_wr && !do_rd) begin
            count_r <= CW'(count_r + 1'b1);
         end else if (do_rd && !do_wr) begin
            count_r <= CW'(count_r - 1'b1);
         end
      end
   end

endmodule : ssp_fifo

// ---- core/ssp_rate.sv ----
`timescale 1ns/1ps
module ssp_rate #(
   parameter int PW = 8,
   parameter int DW = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Control
   input wire logic run_i,
   input wire logic src_sel_i,
   input wire logic osc_tick_i,
   input wire logic [PW-1:0] prescale_i,
   input wire logic [DW-1:0] divider_i,
   // Half bit period pulse
   output logic tick_o
);
   logic [PW-1:0] pre_r;
   logic [DW-1:0] div_r;

   // The oscillator source arrives as a one-cycle enable pulse
   wire src_tick = src_sel_i ? osc_tick_i : 1'b1;
   wire [PW:0] pre_inc = {1'b0, pre_r} + {{PW{1'b0}}, 1'b1};
   // Prescale of zero behaves as one
   wire pre_done = src_tick & (pre_inc >= {1'b0, prescale_i});
   wire div_done = pre_done & (div_r >= divider_i);

   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !run_i) begin
         pre_r <= '0;
         div_r <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= div_done;
         if (pre_done) begin
            pre_r <= '0;
         end else if (src_tick) begin
            pre_r <= pre_inc[PW-1:0];
         end
         if (div_done) begin
            div_r <= '0;
         end else if (pre_done) begin
            div_r <= DW'(div_r + 1'b1);
         end
      end
   end

endmodule : ssp_rate

// ---- core/ssp_core.sv ----
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_core #(
   parameter int DW = `SSP_DATA_W,
   parameter int DEPTH = `SSP_FIFO_DEPTH,
   parameter int PW = `SSP_PRE_W,
   parameter int VW = `SSP_DIV_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Configuration
   input wire logic enable_i,
   input wire logic master_i,
   input wire logic slave_output_off_mode_i,
   input wire logic [1:0] format_i,
   input wire logic [1:0] spi_mode_i,
   input wire logic [3:0] width_m1_i,
   input wire logic [PW-1:0] prescale_i,
   input wire logic [VW-1:0] divider_i,
   input wire logic baud_src_internal_osc_i,
   input wire logic precision_internal_osc_tick_i,
   // DMA and interrupt control
   input wire logic dma_tx_en_i,
   input wire logic dma_rx_en_i,
   input wire logic [`SSP_INT_W-1:0] int_mask_i,
   input wire logic [`SSP_INT_W-1:0] int_clr_i,
   // Transmit word port
   input wire logic tx_write_i,
   input wire logic [DW-1:0] tx_data_i,
   output logic tx_not_full_o,
   // Receive word port
   input wire logic rx_read_i,
   output logic [DW-1:0] rx_data_o,
   output logic rx_not_empty_o,
   // Status
   output logic busy_o,
   output logic baud_src_o,
   output logic [`SSP_INT_W-1:0] int_raw_o,
   output logic [`SSP_INT_W-1:0] int_masked_o,
   output logic dma_tx_req_o,
   output logic dma_rx_req_o,
   // Serial link
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe_b_o,
   input wire logic frm_i,
   output logic frm_o,
   output logic frm_oe_b_o,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_b_o
);
   localparam int CW = $clog2(DEPTH) + 1;

   ssp_pkg::ssp_state_t st_r;
   ssp_pkg::ssp_state_t st_nxt;
   logic [DW-1:0] tx_sh_r;
   logic [DW-1:0] rx_sh_r;
   logic [6:0] edge_cnt_r;
   logic sclk_r;
   logic sclk_d_r;
   logic frm_act_d_r;
   logic pend_r;
   logic ovr_r;
   logic tick;
   logic [DW-1:0] tx_head;
   logic [CW-1:0] tx_count;
   logic [CW-1:0] rx_count;
   logic tx_full;
   logic tx_empty;
   logic rx_full;
   logic rx_empty;
   logic [DW-1:0] rx_head;

   // Format decode
   wire fmt_pulse = (format_i == ssp_pkg::SSP_FMT_PULSE);
   wire fmt_cmd = (format_i == ssp_pkg::SSP_FMT_CMD);
   wire fmt_spi = ~fmt_pulse & ~fmt_cmd;
   wire idle_lvl = fmt_spi & spi_mode_i[1];
   wire samp_lead = fmt_spi ? ~spi_mode_i[0] : fmt_cmd;

   // Frame length; lengths below the minimum are raised to it
   wire [3:0] wm1 = (width_m1_i < `SSP_WIDTH_M1_MIN) ?
                    `SSP_WIDTH_M1_MIN : width_m1_i;
   wire [DW-1:0] wmask = {DW{1'b1}} >> (`SSP_WIDTH_M1_MAX - wm1);
   wire [4:0] nbits = {1'b0, wm1} + 5'h01;
   // Command-response frames carry the command then the reply
   wire [6:0] tx_edges = {1'b0, nbits, 1'b0};
   wire [6:0] total_edges = fmt_cmd ? {nbits, 2'b00} : tx_edges;
   wire first_half = ~fmt_cmd | (edge_cnt_r < tx_edges);
   wire tx_phase = fmt_cmd ? (master_i ? first_half : ~first_half) : 1'b1;

   // Slave frame detection
   wire frm_act = fmt_pulse ? frm_i : ~frm_i;
   wire s_start = ~master_i & frm_act & ~frm_act_d_r;
   wire s_abort = ~master_i & ~fmt_pulse & ~frm_act;
   wire in_idle = (st_r == ssp_pkg::SSP_ST_IDLE);
   wire in_xfer = (st_r == ssp_pkg::SSP_ST_XFER);

   // Frame load and the word it pulls from the transmit buffer
   wire load = in_idle & enable_i &
               (master_i ? ~tx_empty : (s_start | pend_r));
   wire tx_pop = load & ~tx_empty;

   // Clock edges: own divider in master, sampled pin in slave
   wire m_edge = master_i & in_xfer & tick;
   wire s_edge = ~master_i & in_xfer & (sclk_i != sclk_d_r);
   wire edge_ev = m_edge | s_edge;
   wire cur_lvl = master_i ? sclk_r : sclk_d_r;
   wire lead = (cur_lvl == idle_lvl);
   wire samp = edge_ev & (lead == samp_lead);
   wire shft = edge_ev & ~samp & (edge_cnt_r != 7'h00) & tx_phase;
   wire last = edge_ev & (edge_cnt_r == total_edges - 7'h01);
   wire [DW-1:0] rx_next = samp ? {rx_sh_r[DW-2:0], sdi_i} : rx_sh_r;
   wire rx_push = last;
   wire tx_bit = tx_sh_r[wm1];

   // Data pin drive; output-off slaves never drive
   wire drive = enable_i & tx_phase &
                (master_i ? ~in_idle :
                 (in_xfer & ~slave_output_off_mode_i));

   // Master frame signal: select low for a whole frame, or pulse
   wire frm_m = fmt_pulse ? (st_r == ssp_pkg::SSP_ST_START) :
                in_idle;

   // Interrupt sources
   wire tx_low = (tx_count <= CW'(`SSP_FIFO_HALF));
   wire rx_high = (rx_count >= CW'(`SSP_FIFO_HALF));
   // A new overrun in the clearing cycle keeps the flag set
   wire ovr_nxt = (ovr_r & ~int_clr_i[`SSP_INT_RX_OVR]) |
                  (rx_push & rx_full);
   wire [`SSP_INT_W-1:0] raw_nxt = {ovr_nxt, rx_high, tx_low};
   wire busy_nxt = ~tx_empty | ~in_idle;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ssp_pkg::SSP_ST_IDLE: begin
            if (load) begin
               st_nxt = master_i ? ssp_pkg::SSP_ST_START :
                        ssp_pkg::SSP_ST_XFER;
            end
         end
         ssp_pkg::SSP_ST_START: begin
            if (tick) begin
               st_nxt = ssp_pkg::SSP_ST_XFER;
            end
         end
         ssp_pkg::SSP_ST_XFER: begin
            if (last) begin
               st_nxt = master_i ? ssp_pkg::SSP_ST_DONE :
                        ssp_pkg::SSP_ST_IDLE;
            end else if (s_abort) begin
               st_nxt = ssp_pkg::SSP_ST_IDLE;
            end
         end
         ssp_pkg::SSP_ST_DONE: begin
            if (tick) begin
               st_nxt = ssp_pkg::SSP_ST_IDLE;
            end
         end
         default: begin
            st_nxt = ssp_pkg::SSP_ST_IDLE;
         end
      endcase
      if (!enable_i) begin
         st_nxt = ssp_pkg::SSP_ST_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st_r <= ssp_pkg::SSP_ST_IDLE;
         edge_cnt_r <= 7'h00;
      end else begin
         st_r <= st_nxt;
         if (load) begin
            edge_cnt_r <= 7'h00;
         end else if (edge_ev) begin
            edge_cnt_r <= edge_cnt_r + 7'h01;
         end
      end
   end

   // Shift registers; an empty slave buffer sends zeros
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         tx_sh_r <= '0;
         rx_sh_r <= '0;
      end else begin
         if (load) begin
            tx_sh_r <= tx_empty ? '0 : (tx_head & wmask);
         end else if (shft) begin
            tx_sh_r <= {tx_sh_r[DW-2:0], 1'b0};
         end
         rx_sh_r <= load ? '0 : rx_next;
      end
   end

   // Pin sampling; pins are synchronous so one stage is enough
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sclk_d_r <= 1'b0;
         frm_act_d_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_i;
         frm_act_d_r <= frm_act;
         // Back-to-back pulse frames announce during the last bit
         pend_r <= enable_i & ~load & (pend_r | (s_start & ~in_idle));
      end
   end

   // Master clock toggles once per half-bit tick
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sclk_r <= 1'b0;
      end else if (!in_xfer || !master_i) begin
         sclk_r <= idle_lvl;
      end else if (m_edge) begin
         sclk_r <= ~sclk_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sclk_o <= 1'b0;
         sclk_oe_b_o <= 1'b1;
         frm_o <= 1'b1;
         frm_oe_b_o <= 1'b1;
         sdo_o <= 1'b0;
         sdo_oe_b_o <= 1'b1;
      end else begin
         sclk_o <= sclk_r;
         sclk_oe_b_o <= ~master_i;
         frm_o <= frm_m;
         frm_oe_b_o <= ~master_i;
         sdo_o <= tx_bit;
         sdo_oe_b_o <= ~drive;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ovr_r <= 1'b0;
         int_raw_o <= '0;
         int_masked_o <= '0;
      end else begin
         ovr_r <= ovr_nxt;
         int_raw_o <= raw_nxt;
         int_masked_o <= raw_nxt & int_mask_i;
      end
   end

   // Status is registered, so polled flags lag the buffers by a cycle
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         busy_o <= 1'b0;
         baud_src_o <= 1'b0;
         tx_not_full_o <= 1'b0;
         rx_not_empty_o <= 1'b0;
         rx_data_o <= '0;
         dma_tx_req_o <= 1'b0;
         dma_rx_req_o <= 1'b0;
      end else begin
         busy_o <= busy_nxt;
         baud_src_o <= baud_src_internal_osc_i;
         tx_not_full_o <= ~tx_full;
         rx_not_empty_o <= ~rx_empty;
         rx_data_o <= rx_empty ? '0 : rx_head;
         dma_tx_req_o <= dma_tx_en_i & ~tx_full;
         dma_rx_req_o <= dma_rx_en_i & ~rx_empty;
      end
   end

   // Half-bit ticks; the counts are held at zero whenever no master frame is running
   ssp_rate #(
      .PW(PW),
      .DW(VW)
   ) u_rate (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .run_i(master_i & ~in_idle),
      .src_sel_i(baud_src_internal_osc_i),
      .osc_tick_i(precision_internal_osc_tick_i),
      .prescale_i(prescale_i),
      .divider_i(divider_i),
      .tick_o(tick)
   );

   ssp_fifo #(
      .W(DW),
      .DEPTH(DEPTH),
      .CW(CW)
   ) u_tx_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .wr_i(tx_write_i),
      .wr_data_i(tx_data_i & wmask),
      .rd_i(tx_pop),
      .rd_data_o(tx_head),
      .count_o(tx_count),
      .full_o(tx_full),
      .empty_o(tx_empty)
   );

   ssp_fifo #(
      .W(DW),
      .DEPTH(DEPTH),
      .CW(CW)
   ) u_rx_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .wr_i(rx_push),
      .wr_data_i(rx_next & wmask),
      .rd_i(rx_read_i),
      .rd_data_o(rx_head),
      .count_o(rx_count),
      .full_o(rx_full),
      .empty_o(rx_empty)
   );

endmodule : ssp_core

// ---- verif/ssp_core_chk.sv ----
`timescale 1ns/1ps
module ssp_core_chk #(
   parameter int DW = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Controls
   input wire logic enable_i,
   input wire logic master_i,
   input wire logic slave_output_off_mode_i,
   input wire logic [1:0] format_i,
   input wire logic [1:0] spi_mode_i,
   input wire logic baud_src_internal_osc_i,
   input wire logic dma_tx_en_i,
   input wire logic [2:0] int_mask_i,
   // Status and link
   input wire logic busy_o,
   input wire logic baud_src_o,
   input wire logic [2:0] int_masked_o,
   input wire logic dma_tx_req_o,
   input wire logic rx_not_empty_o,
   input wire logic [DW-1:0] rx_data_o,
   input wire logic sclk_o,
   input wire logic sclk_oe_b_o,
   input wire logic frm_o,
   input wire logic frm_oe_b_o,
   input wire logic sdo_oe_b_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_held_off;
      // A frame cut by disable needs three edges to park the pins
      (!enable_i && $stable(spi_mode_i) && $stable(master_i)) [*5];
   endsequence
   sequence s_slave_quiet;
      (!master_i && slave_output_off_mode_i) [*2];
   endsequence

   AST_RST_OUT: assert property ($rose(rst_b_i) |->
      sdo_oe_b_o && sclk_oe_b_o && frm_oe_b_o && frm_o && !busy_o)
      else $error("outputs not idle after reset");
   AST_SLAVE_OFF: assert property (s_slave_quiet |=> sdo_oe_b_o)
      else $error("slave drove data with output off");
   AST_SLAVE_PINS: assert property (!master_i [*2] |=>
      sclk_oe_b_o && frm_oe_b_o)
      else $error("slave drove clock or frame");
   AST_DISABLED_IDLE: assert property (s_held_off |->
      $stable(sclk_o) && $stable(frm_o))
      else $error("link moved while disabled");
   AST_DMA_OFF: assert property (!$past(dma_tx_en_i) |-> !dma_tx_req_o)
      else $error("transmit request while not enabled");
   AST_MASK_ZERO: assert property ((int_mask_i == 3'h0) [*2] |=>
      int_masked_o == 3'h0)
      else $error("masked status set with all masked");
   AST_BAUD_SRC: assert property (baud_src_internal_osc_i [*2] |=>
      baud_src_o)
      else $error("selected source not reported");
   AST_FRAME_BUSY: assert property (master_i && format_i == 2'h0 &&
      !frm_oe_b_o && !frm_o |-> busy_o)
      else $error("frame active without busy");
   AST_RX_EMPTY_ZERO: assert property (!rx_not_empty_o |->
      rx_data_o == '0)
      else $error("receive data not zero when empty");
endmodule : ssp_core_chk

bind ssp_core ssp_core_chk #(.DW(DW)) i_ssp_core_chk (.*);

// ---- verif/ssp_slave_model.sv ----
`timescale 1ns/1ps
module ssp_slave_model (
   // Clock
   input wire logic clk_i,
   // Link from the master
   input wire logic sclk_i,
   input wire logic frm_b_i,
   input wire logic mosi_i,
   output logic miso_o,
   // Setup and data
   input wire logic cpol_i,
   input wire logic cpha_i,
   input wire logic [3:0] width_m1_i,
   input wire logic [15:0] word_i,
   output logic [15:0] got_o
);
   logic sclk_q = 1'b0;
   logic frm_q = 1'b1;
   logic last_r = 1'b0;
   logic [15:0] sh_r = 16'h0;
   logic [5:0] cnt_r = 6'h0;
   wire edge_w = sclk_i != sclk_q;
   wire lead_w = edge_w && (sclk_i != cpol_i);
   wire samp_w = edge_w && (lead_w != cpha_i);
   // Released line shows the inverse so a stale bit never matches
   assign miso_o = !frm_b_i ? sh_r[15] : ~last_r;
   always_ff @(posedge clk_i) begin
      sclk_q <= sclk_i;
      frm_q <= frm_b_i;
      if (!frm_b_i)
         last_r <= sh_r[15];
      if (frm_q && !frm_b_i) begin
         sh_r <= word_i << (4'hf - width_m1_i);
         cnt_r <= 6'h0;
         got_o <= 16'h0;
      end else if (!frm_b_i && edge_w) begin
         if (samp_w)
            got_o <= {got_o[14:0], mosi_i};
         else if (!cpha_i || cnt_r != 6'h0)
            sh_r <= {sh_r[14:0], 1'b0};
         cnt_r <= cnt_r + 6'h1;
      end
   end
endmodule : ssp_slave_model

// ---- verif/ssp_core_bench.sv ----
`timescale 1ns/1ps
module ssp_core_bench;
   logic clk_i = 1'b0, rst_b_i = 1'b0, enable_i = 1'b0, master_i = 1'b1;
   logic slave_output_off_mode_i = 1'b0, baud_src_internal_osc_i = 1'b0;
   logic precision_internal_osc_tick_i = 1'b0, dma_tx_en_i = 1'b0;
   logic dma_rx_en_i = 1'b0, tx_write_i = 1'b0, rx_read_i = 1'b0;
   logic sclk_i = 1'b0, frm_i = 1'b1, sdi_i;
   logic [1:0] format_i = 2'h0, spi_mode_i = 2'h0;
   logic [3:0] width_m1_i = 4'hf;
   logic [7:0] prescale_i = 8'h02, divider_i = 8'h01;
   logic [2:0] int_mask_i = 3'h7, int_clr_i = 3'h0, int_raw_o, int_masked_o;
   logic [15:0] tx_data_i = 16'h0, rx_data_o, got, pw, d;
   logic [15:0] rnd_r = 16'h0027, osc_r = 16'h0027;
   logic tx_not_full_o, rx_not_empty_o, busy_o, baud_src_o, dma_tx_req_o;
   logic dma_rx_req_o, sclk_o, sclk_oe_b_o, frm_o, frm_oe_b_o, sdo_o;
   logic sdo_oe_b_o;
   int mismatches = 0, cmp_count = 0, cyc = 0;

   ssp_core i_ssp_core (.*);
   ssp_slave_model i_ssp_slave_model (.clk_i(clk_i), .sclk_i(sclk_o),
      .frm_b_i(frm_o), .mosi_i(sdo_o), .miso_o(sdi_i),
      .cpol_i(spi_mode_i[1]), .cpha_i(spi_mode_i[0]),
      .width_m1_i(width_m1_i), .word_i(pw), .got_o(got));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [15:0] msk(input logic [3:0] m1);
      return 16'hffff >> (4'hf - m1);
   endfunction : msk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic put(input logic [15:0] v);
      tx_data_i = v;
      tx_write_i = 1'b1;
      tick(1);
      tx_write_i = 1'b0;
      tick(1);
   endtask : put
   task automatic pop(input logic [15:0] e);
      chk(rx_data_o, e);
      rx_read_i = 1'b1;
      tick(1);
      rx_read_i = 1'b0;
      tick(1);
   endtask : pop
   task automatic wait_idle;
      tick(4);
      for (int k = 0; k < 4000 && busy_o !== 1'b0; k++)
         tick(1);
      chk(busy_o, 16'h0);
      tick(2);
   endtask : wait_idle
   task automatic final_report;
      if (mismatches == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      #1;
      osc_r = lfsr(osc_r);
      precision_internal_osc_tick_i = osc_r[0];
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         final_report;
      end
   end

   initial begin
      tick(6);
      rst_b_i = 1'b1;
      tick(1);
      chk(tx_not_full_o, 16'h1);
      chk(int_raw_o, 16'h1);
      enable_i = 1'b1;
      dma_rx_en_i = 1'b1;
      // Bit rate stays far below half the module clock
      for (int i = 0; i < 12; i++) begin
         spi_mode_i = i[1:0];
         rnd_r = lfsr(rnd_r);
         width_m1_i = i < 4 ? 4'h3 : i < 8 ? 4'hf : 4'h3 + rnd_r[3:0] % 4'hd;
         if (i == 8) begin
            baud_src_internal_osc_i = 1'b1;
            // Oscillator ticks may come on back-to-back cycles
            divider_i = 8'h03;
         end
         pw = rnd_r;
         rnd_r = lfsr(rnd_r);
         d = rnd_r;
         put(d);
         wait_idle;
         chk(got, d & msk(width_m1_i));
         pop(pw & msk(width_m1_i));
         if (i == 8)
            chk(baud_src_o, 16'h1);
      end
      enable_i = 1'b0;
      dma_tx_en_i = 1'b1;
      width_m1_i = 4'h7;
      pw = 16'h00a5;
      for (int k = 0; k < 9; k++)
         put(16'h0100 + 16'(k));
      tick(2);
      chk(tx_not_full_o, 16'h0);
      chk(dma_tx_req_o, 16'h0);
      chk(int_raw_o, 16'h0);
      chk(rx_not_empty_o, 16'h0);
      int_mask_i = 3'h2;
      int_clr_i = 3'h4;
      enable_i = 1'b1;
      tick(1);
      int_clr_i = 3'h0;
      wait_idle;
      chk(int_raw_o, 16'h3);
      chk(int_masked_o, 16'h2);
      chk(dma_rx_req_o, 16'h1);
      chk(got, 16'h0007);
      put(16'h0108);
      wait_idle;
      chk(int_raw_o, 16'h7);
      chk(int_masked_o, 16'h2);
      int_clr_i = 3'h4;
      tick(1);
      int_clr_i = 3'h0;
      tick(1);
      chk(int_raw_o, 16'h3);
      for (int k = 0; k < 8; k++)
         pop(16'h00a5);
      chk(rx_not_empty_o, 16'h0);
      master_i = 1'b0;
      slave_output_off_mode_i = 1'b1;
      tick(4);
      chk(sdo_oe_b_o, 16'h1);
      chk(sclk_oe_b_o, 16'h1);
      // No slave clock is driven here, so the ratio cannot be broken
      chk(frm_oe_b_o, 16'h1);
      final_report;
   end
endmodule : ssp_core_bench
